// ---- logic/ldd_consts.svh ----
// Purpose: named constants of the linked descriptor dma engine
// Assumes: included by the package only, both ends use its macros through it
// Notes: register offsets, field positions and counts live here only
`ifndef LDD_CONSTS_SVH
`define LDD_CONSTS_SVH

// ---------------------------------------------------------------
// channel count and register map
// ---------------------------------------------------------------
`define LDD_NCH 16
`define LDD_MAIN_BASE 16'h0000
`define LDD_LAST_BASE 16'h1000
`define LDD_ENABLE_ADDR 16'h0FF0
`define LDD_LAST_CH 4'hF
`define LDD_OFF_CS 8'h00
`define LDD_OFF_CONBLK 8'h04
`define LDD_OFF_TI 8'h08
`define LDD_OFF_SRC 8'h0C
`define LDD_OFF_DST 8'h10
`define LDD_OFF_LEN 8'h14
`define LDD_OFF_STRIDE 8'h18
`define LDD_OFF_NEXT 8'h1C
`define LDD_OFF_DEBUG 8'h20
`define LDD_EN_RESET 16'hFFFF

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define LDD_CS_ACTIVE 0
`define LDD_CS_LOADED 1
`define LDD_TI_PACE 0
`define LDD_TI_PREFETCH 1
`define LDD_TI_BURST_LO 4
`define LDD_TI_PERMAP_LO 16

// ---------------------------------------------------------------
// bus figures
// ---------------------------------------------------------------
`define LDD_CB_MASK 32'hFFFF_FFE0
`define LDD_WORD_MASK 32'hFFFF_FFFC
`define LDD_CB_LEN 4'h7
`define LDD_PRIO_NORM 4'h0
`define LDD_PRIO_HIGH 4'hF
`define LDD_NBUSES 4'h3
`define LDD_BUF_BYTES 64
`define LDD_WIDE_BYTES 7'h08
`define LDD_MEM_WORDS 256
`define LDD_MEM_IDX_LO 2

`endif

// ---- logic/ldd_pkg.sv ----
// Purpose: types shared by the dma engine and its memory end
// Assumes: ldd_consts.svh supplies every figure
// Notes: each module keeps all of its state in one packed struct
`include "ldd_consts.svh"

package ldd_pkg;

   // ---------------------------------------------------------------
   // per channel register set
   // ---------------------------------------------------------------
   typedef struct packed
   {
      logic active;
      logic loaded;
      logic [31:0] conblk;
      logic [31:0] ti;
      logic [31:0] src;
      logic [31:0] dst;
      logic [31:0] len;
      logic [31:0] stride;
      logic [31:0] next;
      logic [31:0] debug;
   } ldd_chan_t;

   typedef enum logic [3:0]
   {
      st_arb, st_fetch_ar, st_fetch_r, st_rd_ar, st_rd_r,
      st_wr_aw, st_wr_w, st_wr_b
   } ldd_state_t;

   // ---------------------------------------------------------------
   // engine state
   // ---------------------------------------------------------------
   typedef struct packed
   {
      ldd_chan_t [`LDD_NCH-1:0] ch;
      logic [`LDD_NCH-1:0] enable;
      ldd_state_t state;
      logic [3:0] cur;
      logic [2:0] widx;
      logic [`LDD_BUF_BYTES-1:0][7:0] pbuf;
      logic [6:0] fill;
      logic [6:0] head;
      logic [6:0] rd_left;
      logic [6:0] wr_left;
      logic [1:0] rd_off;
      logic ar_valid;
      logic [31:0] ar_addr;
      logic [3:0] ar_len;
      logic aw_valid;
      logic [31:0] aw_addr;
      logic [3:0] aw_len;
      logic [3:0] prio;
      logic [1:0] bus_id;
      logic w_valid;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic w_last;
      logic [31:0] rdata;
   } ldd_eng_t;

   // ---------------------------------------------------------------
   // memory end state
   // ---------------------------------------------------------------
   typedef struct packed
   {
      logic [`LDD_MEM_WORDS-1:0][31:0] mem;
      logic rbusy;
      logic [7:0] raddr;
      logic [3:0] rleft;
      logic wbusy;
      logic [7:0] waddr;
      logic ar_ready;
      logic r_valid;
      logic [31:0] r_data;
      logic r_last;
      logic aw_ready;
      logic w_ready;
      logic b_valid;
      logic [31:0] drl;
      logic [31:0] urg;
      logic [31:0] peek;
   } ldd_mem_t;

endpackage

// ---- logic/ldd_if.sv ----
// Purpose: link between the dma engine and memory with peripherals
// Assumes: both ends on the same clk
// Notes: reduced axi style channels, no read data or write response back-pressure
`timescale 1ns/1ps

interface ldd_if;
   // read address and data
   logic ar_valid;
   logic ar_ready;
   logic [31:0] ar_addr;
   logic [3:0] ar_len;
   logic r_valid;
   logic [31:0] r_data;
   logic r_last;
   // write address, data and response
   logic aw_valid;
   logic aw_ready;
   logic [31:0] aw_addr;
   logic [3:0] aw_len;
   logic w_valid;
   logic w_ready;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_last;
   logic b_valid;
   // priority and bus lane shared by both address channels
   logic [3:0] prio;
   logic [1:0] bus_id;
   // peripheral pacing
   logic [31:0] data_request_line;
   logic [31:0] urgency;

   modport engine
   (
      output ar_valid, ar_addr, ar_len, aw_valid, aw_addr, aw_len,
      output w_valid, w_data, w_strb, w_last, prio, bus_id,
      input ar_ready, r_valid, r_data, r_last, aw_ready, w_ready,
      input b_valid, data_request_line, urgency
   );

   modport mem
   (
      input ar_valid, ar_addr, ar_len, aw_valid, aw_addr, aw_len,
      input w_valid, w_data, w_strb, w_last, prio, bus_id,
      output ar_ready, r_valid, r_data, r_last, aw_ready, w_ready,
      output b_valid, data_request_line, urgency
   );
endinterface

// ---- logic/ldd_engine.sv ----
// Purpose: sixteen channel dma engine walking linked descriptors
// Assumes: memory end answers on the same clk, register port is local
// Notes: one datapath is shared, channels rotate at burst granularity
`timescale 1ns/1ps

// What this block does
// - sixteen channels arbitrated onto three buses
// - descriptor loaded from memory, may chain
// - read burst length taken from descriptor
// - writes single beat, wide ones two beats
// - low request line gates data read and write requests, not descriptor fetches
// - urgency raises bus priority
// - request line per channel is programmable
// - byte aligned transfers packed through buffer
// - global enable can switch channels off
// - channels 0x100 apart, channel 15 separate
// - every channel has the same map
// - only control, address, next pointer, debug directly writable
// - software aligns eight word descriptors
// - descriptor words copied in fixed order
// - address then active bit starts channel
// - zero length follows next pointer
// - null next pointer clears active, stops
// - loaded registers readable with live progress
// - next pointer overwritable, safely when paused
// - prefetch mode reads without writing
// - software gives physical peripheral addresses
module ldd_engine
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // memory and peripheral link
   ldd_if.engine bus,
   // register port
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);

   ldd_pkg::ldd_eng_t q;
   ldd_pkg::ldd_eng_t next_q;

   // ---------------------------------------------------------------
   // one write beat: byte lanes from dst offset, bytes from buffer
   // ---------------------------------------------------------------
   function automatic logic [38:0] wbeat(input logic [31:0] dst,
      input logic [6:0] left, input logic [6:0] head,
      input logic [`LDD_BUF_BYTES-1:0][7:0] pb);
      logic [31:0] d;
      logic [3:0] s;
      logic [2:0] n;
      logic [6:0] k;
      d = 32'h0000_0000;
      s = 4'h0;
      n = 3'h0;
      k = 7'h00;
      for (int l = 0; l < 4; l++)
      begin
         if (l >= int'(dst[1:0]) && {4'h0, n} < left)
         begin
            k = head + {4'h0, n};
            d[l*8 +: 8] = pb[k[5:0]];
            s[l] = 1'b1;
            n = n + 3'h1;
         end
      end
      return {n, s, d};
   endfunction

   // ---------------------------------------------------------------
   // register port decode
   // ---------------------------------------------------------------
   logic hit;
   logic [3:0] sel;
   logic [7:0] off;

   always_comb
   begin
      off = reg_addr[7:0];
      sel = reg_addr[11:8];
      hit = 1'b0;
      if (reg_addr[15:12] == `LDD_MAIN_BASE >> 12 &&
         reg_addr[11:8] != `LDD_LAST_CH)
         hit = 1'b1;
      else if (reg_addr[15:8] == `LDD_LAST_BASE >> 8)
      begin
         hit = 1'b1;
         sel = `LDD_LAST_CH;
      end
   end

   // ---------------------------------------------------------------
   // engine and register next state
   // ---------------------------------------------------------------
   always_comb
   begin
      logic found;
      logic [3:0] c;
      logic [4:0] line;
      logic paced;
      logic [1:0] so;
      logic [6:0] maxb;
      logic [6:0] chunk;
      logic [6:0] beats;
      logic [2:0] n;
      logic [6:0] k;
      logic [31:0] nd;
      logic [6:0] nl;
      logic [6:0] nh;
      logic [38:0] bt;
      ldd_pkg::ldd_chan_t cc;
      next_q = q;
      found = 1'b0;
      c = 4'h0;
      line = q.ch[q.cur].ti[`LDD_TI_PERMAP_LO +: 5];
      paced = q.ch[q.cur].ti[`LDD_TI_PACE] &&
         !bus.data_request_line[line];
      so = 2'h0;
      maxb = 7'h00;
      chunk = 7'h00;
      beats = 7'h00;
      n = 3'h0;
      k = 7'h00;
      nd = 32'h0000_0000;
      nl = 7'h00;
      nh = 7'h00;
      bt = 39'h0;
      cc = q.ch[q.cur];
      case (q.state)
         ldd_pkg::st_arb:
         begin
            // rotate from the last served channel so none starves
            for (int i = 1; i <= `LDD_NCH; i++)
            begin
               if (!found && q.ch[4'(q.cur + 4'(i))].active &&
                  q.enable[4'(q.cur + 4'(i))])
               begin
                  found = 1'b1;
                  c = 4'(q.cur + 4'(i));
               end
            end
            if (found)
            begin
               cc = q.ch[c];
               line = cc.ti[`LDD_TI_PERMAP_LO +: 5];
               next_q.cur = c;
               next_q.bus_id = 2'(c % `LDD_NBUSES);
               next_q.prio = bus.urgency[line] ? `LDD_PRIO_HIGH :
                  `LDD_PRIO_NORM;
               if (!cc.loaded)
               begin
                  next_q.ar_addr = cc.conblk & `LDD_CB_MASK;
                  next_q.ar_len = `LDD_CB_LEN;
                  next_q.ar_valid = 1'b1;
                  next_q.widx = 3'h0;
                  next_q.state = ldd_pkg::st_fetch_ar;
               end
               else if (cc.len == 32'h0000_0000)
               begin
                  next_q.ch[c].conblk = cc.next;
                  next_q.ch[c].loaded = 1'b0;
                  if (cc.next == 32'h0000_0000)
                     next_q.ch[c].active = 1'b0;
               end
               else
               begin
                  so = cc.src[1:0];
                  beats = {3'h0, cc.ti[`LDD_TI_BURST_LO +: 4]} + 7'h01;
                  maxb = 7'(beats << 2) - {5'h00, so};
                  chunk = (cc.len < {25'h0, maxb}) ? cc.len[6:0] : maxb;
                  next_q.ar_addr = cc.src & `LDD_WORD_MASK;
                  next_q.ar_len = 4'(((7'(so) + chunk + 7'h03) >> 2)
                     - 7'h01);
                  next_q.rd_left = chunk;
                  next_q.rd_off = so;
                  next_q.fill = 7'h00;
                  next_q.state = ldd_pkg::st_rd_ar;
               end
            end
         end
         ldd_pkg::st_fetch_ar:
            if (q.ar_valid && bus.ar_ready)
            begin
               next_q.ar_valid = 1'b0;
               next_q.state = ldd_pkg::st_fetch_r;
            end
         ldd_pkg::st_fetch_r:
            if (bus.r_valid)
            begin
               // words six and seven are dropped
               case (q.widx)
                  3'h0: next_q.ch[q.cur].ti = bus.r_data;
                  3'h1: next_q.ch[q.cur].src = bus.r_data;
                  3'h2: next_q.ch[q.cur].dst = bus.r_data;
                  3'h3: next_q.ch[q.cur].len = bus.r_data;
                  3'h4: next_q.ch[q.cur].stride = bus.r_data;
                  3'h5: next_q.ch[q.cur].next = bus.r_data;
                  default: next_q.widx = q.widx;
               endcase
               next_q.widx = q.widx + 3'h1;
               if (bus.r_last)
               begin
                  next_q.ch[q.cur].loaded = 1'b1;
                  next_q.state = ldd_pkg::st_arb;
               end
            end
         ldd_pkg::st_rd_ar:
            // valid may fall while paced, a limit of this link
            if (q.ar_valid && bus.ar_ready)
            begin
               next_q.ar_valid = 1'b0;
               next_q.state = ldd_pkg::st_rd_r;
            end
            else
               next_q.ar_valid = !paced;
         ldd_pkg::st_rd_r:
            if (bus.r_valid)
            begin
               for (int l = 0; l < 4; l++)
               begin
                  if (l >= int'(q.rd_off) && {4'h0, n} < q.rd_left)
                  begin
                     k = q.fill + {4'h0, n};
                     next_q.pbuf[k[5:0]] = bus.r_data[l*8 +: 8];
                     n = n + 3'h1;
                  end
               end
               next_q.rd_off = 2'h0;
               next_q.fill = q.fill + {4'h0, n};
               next_q.rd_left = q.rd_left - {4'h0, n};
               next_q.ch[q.cur].src = cc.src + {29'h0, n};
               if (cc.ti[`LDD_TI_PREFETCH])
                  next_q.ch[q.cur].len = cc.len - {29'h0, n};
               if (bus.r_last)
               begin
                  next_q.head = 7'h00;
                  next_q.wr_left = q.fill + {4'h0, n};
                  next_q.state = cc.ti[`LDD_TI_PREFETCH] ?
                     ldd_pkg::st_arb : ldd_pkg::st_wr_aw;
               end
            end
         ldd_pkg::st_wr_aw:
            if (q.aw_valid && bus.aw_ready)
            begin
               bt = wbeat(cc.dst, q.wr_left, q.head, q.pbuf);
               next_q.aw_valid = 1'b0;
               next_q.w_valid = 1'b1;
               next_q.w_data = bt[31:0];
               next_q.w_strb = bt[35:32];
               next_q.w_last = (q.aw_len == 4'h0);
               next_q.state = ldd_pkg::st_wr_w;
            end
            else
            begin
               next_q.aw_valid = !paced;
               next_q.aw_addr = cc.dst & `LDD_WORD_MASK;
               next_q.aw_len = (cc.dst[1:0] == 2'h0 &&
                  q.wr_left >= `LDD_WIDE_BYTES) ? 4'h1 : 4'h0;
            end
         ldd_pkg::st_wr_w:
            if (q.w_valid && bus.w_ready)
            begin
               bt = wbeat(cc.dst, q.wr_left, q.head, q.pbuf);
               n = bt[38:36];
               nd = cc.dst + {29'h0, n};
               nl = q.wr_left - {4'h0, n};
               nh = q.head + {4'h0, n};
               next_q.ch[q.cur].dst = nd;
               next_q.ch[q.cur].len = cc.len - {29'h0, n};
               next_q.wr_left = nl;
               next_q.head = nh;
               if (q.w_last)
               begin
                  next_q.w_valid = 1'b0;
                  next_q.state = ldd_pkg::st_wr_b;
               end
               else
               begin
                  bt = wbeat(nd, nl, nh, q.pbuf);
                  next_q.w_data = bt[31:0];
                  next_q.w_strb = bt[35:32];
                  next_q.w_last = 1'b1;
               end
            end
         ldd_pkg::st_wr_b:
            if (bus.b_valid)
               next_q.state = (q.wr_left == 7'h00) ?
                  ldd_pkg::st_arb : ldd_pkg::st_wr_aw;
         default: next_q.state = ldd_pkg::st_arb;
      endcase

      // software writes come last so a start beats a same-cycle stop
      if (reg_wr && reg_addr == `LDD_ENABLE_ADDR)
         next_q.enable = reg_wdata[`LDD_NCH-1:0];
      else if (reg_wr && hit)
         case (off)
            `LDD_OFF_CS:
               next_q.ch[sel].active = reg_wdata[`LDD_CS_ACTIVE];
            `LDD_OFF_CONBLK: next_q.ch[sel].conblk = reg_wdata;
            `LDD_OFF_NEXT: next_q.ch[sel].next = reg_wdata;
            `LDD_OFF_DEBUG: next_q.ch[sel].debug = reg_wdata;
            default: next_q.ch[sel].debug = next_q.ch[sel].debug;
         endcase

      // read data stand in the cycle after the strobe only
      next_q.rdata = 32'h0000_0000;
      if (reg_rd && reg_addr == `LDD_ENABLE_ADDR)
         next_q.rdata = {16'h0000, q.enable};
      else if (reg_rd && hit)
         case (off)
            `LDD_OFF_CS: next_q.rdata = {30'h0, q.ch[sel].loaded,
               q.ch[sel].active};
            `LDD_OFF_CONBLK: next_q.rdata = q.ch[sel].conblk;
            `LDD_OFF_TI: next_q.rdata = q.ch[sel].ti;
            `LDD_OFF_SRC: next_q.rdata = q.ch[sel].src;
            `LDD_OFF_DST: next_q.rdata = q.ch[sel].dst;
            `LDD_OFF_LEN: next_q.rdata = q.ch[sel].len;
            `LDD_OFF_STRIDE: next_q.rdata = q.ch[sel].stride;
            `LDD_OFF_NEXT: next_q.rdata = q.ch[sel].next;
            `LDD_OFF_DEBUG: next_q.rdata = q.ch[sel].debug;
            default: next_q.rdata = 32'h0000_0000;
         endcase
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         q <= '0;
         q.enable <= `LDD_EN_RESET;
      end
      else
         q <= next_q;
   end

   // outputs straight from the state register
   assign reg_rdata = q.rdata;
   assign bus.ar_valid = q.ar_valid;
   assign bus.ar_addr = q.ar_addr;
   assign bus.ar_len = q.ar_len;
   assign bus.aw_valid = q.aw_valid;
   assign bus.aw_addr = q.aw_addr;
   assign bus.aw_len = q.aw_len;
   assign bus.w_valid = q.w_valid;
   assign bus.w_data = q.w_data;
   assign bus.w_strb = q.w_strb;
   assign bus.w_last = q.w_last;
   assign bus.prio = q.prio;
   assign bus.bus_id = q.bus_id;
endmodule

// ---- logic/ldd_mem.sv ----
// Purpose: memory and peripheral end facing the dma engine
// Assumes: 1 KB word memory, addresses wrap, same clk as engine
// Notes: request and urgency levels are set from the user side
`timescale 1ns/1ps

module ldd_mem
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // link to the engine
   ldd_if.mem bus,
   // memory load and peek port
   input wire logic [7:0] load_addr,
   input wire logic [31:0] load_data,
   input wire logic load_wr,
   output logic [31:0] peek_data,
   // peripheral levels
   input wire logic [31:0] req_level,
   input wire logic [31:0] urgency_level
);

   ldd_pkg::ldd_mem_t q;
   ldd_pkg::ldd_mem_t next_q;

   // ---------------------------------------------------------------
   // burst reader and strobed writer
   // ---------------------------------------------------------------
   always_comb
   begin
      next_q = q;
      next_q.r_valid = 1'b0;
      next_q.r_last = 1'b0;
      next_q.b_valid = 1'b0;
      // descriptors and data come back one beat per cycle
      if (q.rbusy)
      begin
         next_q.r_valid = 1'b1;
         next_q.r_data = q.mem[q.raddr];
         next_q.r_last = (q.rleft == 4'h0);
         next_q.raddr = q.raddr + 8'h01;
         next_q.rleft = q.rleft - 4'h1;
         if (q.rleft == 4'h0)
         begin
            next_q.rbusy = 1'b0;
            next_q.ar_ready = 1'b1;
         end
      end
      else if (bus.ar_valid && q.ar_ready)
      begin
         next_q.rbusy = 1'b1;
         next_q.ar_ready = 1'b0;
         next_q.raddr = bus.ar_addr[`LDD_MEM_IDX_LO +: 8];
         next_q.rleft = bus.ar_len;
      end
      if (q.wbusy && bus.w_valid && q.w_ready)
      begin
         for (int l = 0; l < 4; l++)
            if (bus.w_strb[l])
               next_q.mem[q.waddr][l*8 +: 8] = bus.w_data[l*8 +: 8];
         next_q.waddr = q.waddr + 8'h01;
         if (bus.w_last)
         begin
            next_q.wbusy = 1'b0;
            next_q.w_ready = 1'b0;
            next_q.b_valid = 1'b1;
            next_q.aw_ready = 1'b1;
         end
      end
      else if (!q.wbusy && bus.aw_valid && q.aw_ready)
      begin
         next_q.wbusy = 1'b1;
         next_q.aw_ready = 1'b0;
         next_q.w_ready = 1'b1;
         next_q.waddr = bus.aw_addr[`LDD_MEM_IDX_LO +: 8];
      end
      // the user load port wins over a same-cycle link write
      if (load_wr)
         next_q.mem[load_addr] = load_data;
      next_q.peek = q.mem[load_addr];
      next_q.drl = req_level;
      next_q.urg = urgency_level;
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         q <= '0;
         q.ar_ready <= 1'b1;
         q.aw_ready <= 1'b1;
      end
      else
         q <= next_q;
   end

   assign peek_data = q.peek;
   assign bus.ar_ready = q.ar_ready;
   assign bus.r_valid = q.r_valid;
   assign bus.r_data = q.r_data;
   assign bus.r_last = q.r_last;
   assign bus.aw_ready = q.aw_ready;
   assign bus.w_ready = q.w_ready;
   assign bus.b_valid = q.b_valid;
   assign bus.data_request_line = q.drl;
   assign bus.urgency = q.urg;
endmodule

// ---- verif/ldd_properties.sv ----
// Purpose: link properties between the dma engine and memory end
// Assumes: one clock, synchronous active high reset
// Notes: sees only interface signals, no bind
`timescale 1ns/1ps

module ldd_properties
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // read side
   input wire logic ar_valid,
   input wire logic ar_ready,
   input wire logic [3:0] ar_len,
   input wire logic r_valid,
   input wire logic r_last,
   // write side
   input wire logic aw_valid,
   input wire logic [3:0] aw_len,
   input wire logic w_valid,
   input wire logic w_ready,
   input wire logic w_last,
   input wire logic b_valid,
   // qualifiers
   input wire logic [3:0] prio,
   input wire logic [1:0] bus_id
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // ----------
   // assertions
   // ----------
   a_prio_level: assert property (prio == 4'h0 || prio == 4'hF)
      else $error("priority neither normal nor raised");
   a_bus_lane: assert property (bus_id != 2'h3)
      else $error("bus lane out of range");
   a_wr_beats: assert property (aw_valid |-> aw_len <= 4'h1)
      else $error("write burst longer than two beats");
   a_one_txn: assert property (!(ar_valid && aw_valid))
      else $error("read and write requested together");
   a_fetch_beats: assert property (ar_valid && ar_ready
      && ar_len == 4'h7
      |-> ##2 (r_valid && !r_last) [*7] ##1 (r_valid && r_last))
      else $error("descriptor fetch not eight beats");
   a_r_latency: assert property (ar_valid && ar_ready |-> ##2 r_valid)
      else $error("read data late");
   a_ar_busy: assert property (ar_valid && ar_ready |=> !ar_ready)
      else $error("second read taken during burst");
   a_b_resp: assert property (w_valid && w_ready && w_last |=> b_valid)
      else $error("write response missing");
   a_reset_idle: assert property ($fell(reset)
      |-> !ar_valid && !aw_valid && !w_valid && prio == 4'h0)
      else $error("link busy right after reset");
   // main scenarios reached
   c_fetch: cover property (ar_valid && ar_ready && ar_len == 4'h7);
   c_wide: cover property (aw_valid && aw_len == 4'h1);
   c_urgent: cover property (prio == 4'hF);
endmodule

// ---- verif/tb_top.sv ----
// Purpose: bench joining the dma engine to its memory end
// Assumes: descriptors preloaded through the load port
// Notes: channel 0 walks a two entry chain, channel 15 is paced
`timescale 1ns/1ps

module tb_top;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [7:0] load_addr = 8'h00;
   logic [31:0] load_data = 32'h0;
   logic load_wr = 1'b0;
   logic [31:0] peek_data;
   logic [31:0] req_level = 32'h0;
   logic [31:0] urgency_level = 32'h0;
   logic [31:0] d;
   logic raised = 1'b0;
   int n_mismatch = 0;
   int checked = 0;
   // reset reads: address, expected value; last unmapped
   logic [47:0] rows [6] = '{{16'h0000, 32'h0}, {16'h0FF0, 32'hFFFF},
      {16'h1000, 32'h0}, {16'h0114, 32'h0}, {16'h0E1C, 32'h0},
      {16'h0F00, 32'h0}};
   // memory image: a two entry chain, a paced one, data
   logic [39:0] img [16] = '{{8'h10, 32'h10}, {8'h11, 32'h100},
      {8'h12, 32'h180}, {8'h13, 32'h8}, {8'h15, 32'h60}, {8'h18, 32'h10},
      {8'h19, 32'h108}, {8'h1A, 32'h1A0}, {8'h1B, 32'h4},
      {8'h20, 32'h30011}, {8'h21, 32'h100}, {8'h22, 32'h1C0},
      {8'h23, 32'h4}, {8'h40, 32'h11223344}, {8'h41, 32'h55667788},
      {8'h42, 32'h99AABBCC}};

   always #4 clk = ~clk;

   ldd_if link();
   ldd_engine ldd_engine_inst(.clk(clk), .reset(reset), .bus(link),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   ldd_mem ldd_mem_inst(.clk(clk), .reset(reset), .bus(link),
      .load_addr(load_addr), .load_data(load_data), .load_wr(load_wr),
      .peek_data(peek_data), .req_level(req_level),
      .urgency_level(urgency_level));
   ldd_properties ldd_properties_inst(.clk(clk), .reset(reset),
      .ar_valid(link.ar_valid), .ar_ready(link.ar_ready),
      .ar_len(link.ar_len), .r_valid(link.r_valid), .r_last(link.r_last),
      .aw_valid(link.aw_valid), .aw_len(link.aw_len),
      .w_valid(link.w_valid), .w_ready(link.w_ready),
      .w_last(link.w_last), .b_valid(link.b_valid), .prio(link.prio),
      .bus_id(link.bus_id));

   // note whether raised priority reached the link
   always @(posedge clk)
      if (link.prio === 4'hF)
         raised <= 1'b1;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // read data stand only the cycle after the strobe
   task automatic rd(input logic [15:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   task automatic ld(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      load_addr <= a;
      load_data <= v;
      load_wr <= 1'b1;
      @(posedge clk);
      load_wr <= 1'b0;
   endtask

   task automatic pk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      load_addr <= a;
      repeat (2) @(posedge clk);
      #1 chk(peek_data, e);
   endtask

   // bounded poll of active bit; timeout is a mismatch
   task automatic wait_idle(input logic [15:0] base);
      int i;
      for (i = 0; i < 300; i++)
      begin
         rd(base, d);
         if (d[0] === 1'b0)
            break;
      end
      if (i == 300)
      begin
         chk(d, 32'h0);
         finish_test();
      end
   endtask

   initial
   begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      foreach (rows[i])
      begin
         rd(rows[i][47:32], d);
         chk(d, rows[i][31:0]);
      end
      wr(16'h0008, 32'h12345678);
      wr(16'h0020, 32'h5);
      rd(16'h0008, d);
      chk(d, 32'h0);
      rd(16'h0020, d);
      chk(d, 32'h5);
      $display("register test done");
      foreach (img[i])
         ld(img[i][39:32], img[i][31:0]);
      wr(16'h0004, 32'h40);
      wr(16'h0000, 32'h1);
      wait_idle(16'h0000);
      rd(16'h0004, d);
      chk(d, 32'h0);
      rd(16'h0008, d);
      chk(d, 32'h10);
      rd(16'h0014, d);
      chk(d, 32'h0);
      pk(8'h60, 32'h11223344);
      pk(8'h61, 32'h55667788);
      pk(8'h68, 32'h99AABBCC);
      $display("chain test done");
      wr(16'h1004, 32'h80);
      wr(16'h1000, 32'h1);
      repeat (40) @(posedge clk);
      rd(16'h1000, d);
      chk(d & 32'h1, 32'h1);
      pk(8'h70, 32'h0);
      @(posedge clk);
      urgency_level <= 32'h8;
      req_level <= 32'h8;
      wait_idle(16'h1000);
      pk(8'h70, 32'h11223344);
      chk({31'h0, raised}, 32'h1);
      ld(8'h20, 32'h2);
      ld(8'h21, 32'h104);
      wr(16'h1004, 32'h80);
      wr(16'h1000, 32'h1);
      wait_idle(16'h1000);
      rd(16'h1014, d);
      chk(d, 32'h0);
      pk(8'h70, 32'h11223344);
      $display("pacing and prefetch test done");
      finish_test();
   end
endmodule
